// >>> logic/pssbc_params.svh
// Offsets, field positions, reset values and timing constants.
`ifndef PSSBC_PARAMS_SVH
`define PSSBC_PARAMS_SVH
`define PSSBC_IDX_GROUP 8'h19
`define PSSBC_IDX_PERIOD 8'h1a
`define PSSBC_IDX_TRIM 8'h1b
`define PSSBC_IDX_FAULT 8'h1c
`define PSSBC_IDX_CTRL 8'h30
`define PSSBC_IDX_STATUS 8'h31
`define PSSBC_IDX_MASK 8'h32
`define PSSBC_RST_GROUP 8'h30
`define PSSBC_RST_PERIOD 8'h00
`define PSSBC_RST_TRIM 8'h82
`define PSSBC_RST_FAULT 8'h02
`define PSSBC_RST_CTRL 8'h01
`define PSSBC_GROUP_MASK 8'h3f
`define PSSBC_PER_SE_BIT 7
`define PSSBC_TRIM_DIS_BIT 1
`define PSSBC_TRIM_DONE_BIT 6
`define PSSBC_CTRL_SHUT_BIT 0
`define PSSBC_CTRL_ALL_BIT 5
`define PSSBC_EV_FAULT 0
`define PSSBC_EV_STARTED 1
`define PSSBC_EV_STOPPED 2
`define PSSBC_EV_TRIMMED 3
`define PSSBC_CLK_NS 10
`define PSSBC_TICK_NS 100000
`define PSSBC_HALF_NS 1302
`define PSSBC_TRIM_CYCLES 32
`endif

// >>> logic/pssbc_pkg.sv
// Types shared by the start/stop back-end control block.
package pssbc_pkg;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SOFT_START = 3'b001,
		ST_RUN = 3'b010,
		ST_SOFT_STOP = 3'b011,
		ST_FAULT = 3'b100
	} pssbc_state_t;
endpackage

// >>> logic/pssbc_top.sv
// PWM channel start/stop, soft period, trim and power stage fault control.
//
// The implementer's own choice: register access over AHB-Lite.
`include "pssbc_params.svh"
module pssbc_top #(
	parameter int CHANNELS = 6,
	parameter int TICK_CYCLES = `PSSBC_TICK_NS / `PSSBC_CLK_NS,
	parameter int HALF_CYCLES = `PSSBC_HALF_NS / `PSSBC_CLK_NS
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [CHANNELS-1:0] PWM_IN,
	input wire logic POWER_STAGE_FAULT_N,
	output logic [CHANNELS-1:0] PWM_OUT,
	output logic [CHANNELS-1:0] VALID_OUT,
	output logic SINGLE_ENDED_LOAD,
	output logic OSC_TRIM_APPLY,
	output logic IRQ
);
	localparam int TRIM_WAIT_MAX = 40;
	logic [7:0] channel_shutdown_group;
	logic [7:0] soft_start_stop_period;
	logic [7:0] oscillator_trim_control;
	logic [7:0] backend_fault_wait;
	logic [7:0] ctrl;
	logic [3:0] status;
	logic [3:0] mask;
	logic [3:0] events;
	logic wr_pend;
	logic [7:0] wr_idx;
	logic addr_ok;
	logic [7:0] addr_idx;
	logic [7:0] rd_val;
	logic fault_meta;
	logic fault_n_s;
	logic trim_done;
	logic [5:0] trim_cnt;
	logic [31:0] tick_cnt;
	logic tick;
	logic [31:0] half_cnt;
	logic half_wave;
	logic [17:0] wait_cnt;
	logic [CHANNELS-1:0] active;
	logic [CHANNELS-1:0] next_pwm;
	logic start_req;
	logic stop_req;
	pssbc_pkg::pssbc_state_t state;

	// Soft period lengths in 0.1 ms ticks.
	function automatic logic [17:0] soft_ticks(input logic [4:0] code);
		case (code)
			5'h08: soft_ticks = 18'd165;
			5'h09: soft_ticks = 18'd239;
			5'h0a: soft_ticks = 18'd314;
			5'h0b: soft_ticks = 18'd404;
			5'h0c: soft_ticks = 18'd539;
			5'h0d: soft_ticks = 18'd703;
			5'h0e: soft_ticks = 18'd942;
			5'h0f: soft_ticks = 18'd1257;
			5'h10: soft_ticks = 18'd1646;
			5'h11: soft_ticks = 18'd2394;
			5'h12: soft_ticks = 18'd3142;
			5'h13: soft_ticks = 18'd4039;
			5'h14: soft_ticks = 18'd5386;
			5'h15: soft_ticks = 18'd7031;
			5'h16: soft_ticks = 18'd9425;
			5'h17: soft_ticks = 18'd12566;
			5'h18: soft_ticks = 18'd17281;
			5'h19: soft_ticks = 18'd25136;
			5'h1a: soft_ticks = 18'd32991;
			5'h1b: soft_ticks = 18'd42417;
			5'h1c: soft_ticks = 18'd56556;
			5'h1d: soft_ticks = 18'd73837;
			5'h1e: soft_ticks = 18'd98973;
			5'h1f: soft_ticks = 18'd131964;
			default: soft_ticks = 18'd0;
		endcase
	endfunction

	// Fault wait lengths in 0.1 ms ticks; large codes saturate.
	function automatic logic [17:0] fault_ticks(input logic [3:0] code);
		case (code)
			4'h0: fault_ticks = 18'd0;
			4'h1: fault_ticks = 18'd1500;
			4'h2: fault_ticks = 18'd2990;
			4'h3: fault_ticks = 18'd4490;
			4'h4: fault_ticks = 18'd5980;
			4'h5: fault_ticks = 18'd7480;
			4'h6: fault_ticks = 18'd8980;
			4'h7: fault_ticks = 18'd10470;
			4'h8: fault_ticks = 18'd11970;
			4'h9: fault_ticks = 18'd13460;
			default: fault_ticks = 18'd14960;
		endcase
	endfunction

	// AHB-Lite slave: zero wait states, always OKAY.
	assign addr_idx = HADDR[9:2];
	assign addr_ok = HSEL && HTRANS[1] && HREADY;

	always_comb begin
		case (addr_idx)
			`PSSBC_IDX_GROUP: rd_val = channel_shutdown_group;
			`PSSBC_IDX_PERIOD: rd_val = soft_start_stop_period;
			`PSSBC_IDX_TRIM: rd_val = {oscillator_trim_control[7], trim_done,
				oscillator_trim_control[5:0]};
			`PSSBC_IDX_FAULT: rd_val = backend_fault_wait;
			`PSSBC_IDX_CTRL: rd_val = ctrl;
			`PSSBC_IDX_STATUS: rd_val = {4'h0, status};
			`PSSBC_IDX_MASK: rd_val = {4'h0, mask};
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			wr_pend <= addr_ok && HWRITE;
			wr_idx <= addr_idx;
			if (addr_ok && !HWRITE) begin
				HRDATA <= {24'h00_0000, rd_val};
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			channel_shutdown_group <= `PSSBC_RST_GROUP;
			soft_start_stop_period <= `PSSBC_RST_PERIOD;
			oscillator_trim_control <= `PSSBC_RST_TRIM;
			backend_fault_wait <= `PSSBC_RST_FAULT;
			ctrl <= `PSSBC_RST_CTRL;
			mask <= 4'h0;
		end else if (wr_pend) begin
			case (wr_idx)
				`PSSBC_IDX_GROUP: channel_shutdown_group <=
					HWDATA[7:0] & `PSSBC_GROUP_MASK;
				`PSSBC_IDX_PERIOD: soft_start_stop_period <= HWDATA[7:0];
				`PSSBC_IDX_TRIM: oscillator_trim_control <=
					{1'b1, 5'h00, HWDATA[1], 1'b0};
				`PSSBC_IDX_FAULT: backend_fault_wait <= {4'h0, HWDATA[3:0]};
				`PSSBC_IDX_CTRL: ctrl <= HWDATA[7:0] & 8'h21;
				`PSSBC_IDX_MASK: mask <= HWDATA[3:0];
				default: ;
			endcase
		end
	end

	// Sticky events: a new event wins over a clear in the same cycle.
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			status <= 4'h0;
		end else if (wr_pend && wr_idx == `PSSBC_IDX_STATUS) begin
			status <= (status & ~HWDATA[3:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status & mask);
		end
	end

	// Fault pin synchroniser.
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			fault_meta <= 1'b1;
			fault_n_s <= 1'b1;
		end else begin
			fault_meta <= POWER_STAGE_FAULT_N;
			fault_n_s <= fault_meta;
		end
	end

	// Internal oscillator trim; the reference stays internal.
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			trim_cnt <= 6'h00;
			trim_done <= 1'b0;
			OSC_TRIM_APPLY <= 1'b0;
		end else if (oscillator_trim_control[`PSSBC_TRIM_DIS_BIT]) begin
			trim_cnt <= 6'h00;
			trim_done <= 1'b0;
			OSC_TRIM_APPLY <= 1'b0;
		end else begin
			OSC_TRIM_APPLY <= 1'b1;
			if (trim_cnt == 6'(`PSSBC_TRIM_CYCLES)) begin
				trim_done <= 1'b1;
			end else begin
				trim_cnt <= trim_cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			half_cnt <= 32'h0000_0000;
			half_wave <= 1'b0;
		end else if (half_cnt == 32'(HALF_CYCLES - 1)) begin
			half_cnt <= 32'h0000_0000;
			half_wave <= ~half_wave;
		end else begin
			half_cnt <= half_cnt + 32'h0000_0001;
		end
	end

	assign start_req = !ctrl[`PSSBC_CTRL_SHUT_BIT];
	assign stop_req = ctrl[`PSSBC_CTRL_SHUT_BIT];

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			state <= pssbc_pkg::ST_OFF;
			active <= '0;
			wait_cnt <= 18'd0;
			events <= 4'h0;
		end else begin
			events[2:0] <= 3'b000;
			events[`PSSBC_EV_TRIMMED] <= trim_cnt == 6'(`PSSBC_TRIM_CYCLES)
				&& !trim_done;
			if (!fault_n_s && state != pssbc_pkg::ST_FAULT) begin
				state <= pssbc_pkg::ST_FAULT;
				wait_cnt <= fault_ticks(backend_fault_wait[3:0]);
				events[`PSSBC_EV_FAULT] <= 1'b1;
			end else begin
				case (state)
					pssbc_pkg::ST_OFF: begin
						active <= '0;
						if (start_req) begin
							if (ctrl[`PSSBC_CTRL_ALL_BIT]) begin
								active <= '1;
							end else begin
								active <= ~channel_shutdown_group[CHANNELS-1:0];
							end
							wait_cnt <= soft_ticks(soft_start_stop_period[4:0]);
							if (soft_start_stop_period[4:3] == 2'b00) begin
								state <= pssbc_pkg::ST_RUN;
								events[`PSSBC_EV_STARTED] <= 1'b1;
							end else begin
								state <= pssbc_pkg::ST_SOFT_START;
							end
						end
					end
					pssbc_pkg::ST_SOFT_START: begin
						if (wait_cnt == 18'd0) begin
							state <= pssbc_pkg::ST_RUN;
							events[`PSSBC_EV_STARTED] <= 1'b1;
						end else if (tick) begin
							wait_cnt <= wait_cnt - 18'd1;
						end
					end
					pssbc_pkg::ST_RUN: begin
						if (stop_req) begin
							wait_cnt <= soft_ticks(soft_start_stop_period[4:0]);
							if (soft_start_stop_period[4:3] == 2'b00) begin
								state <= pssbc_pkg::ST_OFF;
								events[`PSSBC_EV_STOPPED] <= 1'b1;
							end else begin
								state <= pssbc_pkg::ST_SOFT_STOP;
							end
						end
					end
					pssbc_pkg::ST_SOFT_STOP: begin
						if (wait_cnt == 18'd0) begin
							state <= pssbc_pkg::ST_OFF;
							events[`PSSBC_EV_STOPPED] <= 1'b1;
						end else if (tick) begin
							wait_cnt <= wait_cnt - 18'd1;
						end
					end
					pssbc_pkg::ST_FAULT: begin
						active <= '0;
						if (wait_cnt != 18'd0) begin
							if (tick) begin
								wait_cnt <= wait_cnt - 18'd1;
							end
						end else if (fault_n_s) begin
							state <= pssbc_pkg::ST_OFF;
						end
					end
					default: state <= pssbc_pkg::ST_OFF;
				endcase
			end
		end
	end

	always_comb begin
		case (state)
			pssbc_pkg::ST_RUN: next_pwm = PWM_IN & active;
			pssbc_pkg::ST_SOFT_START,
			pssbc_pkg::ST_SOFT_STOP: next_pwm = half_wave ? active : '0;
			default: next_pwm = '0;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			PWM_OUT <= '0;
			VALID_OUT <= '0;
			SINGLE_ENDED_LOAD <= 1'b0;
		end else begin
			SINGLE_ENDED_LOAD <= soft_start_stop_period[`PSSBC_PER_SE_BIT];
			if (!fault_n_s || state == pssbc_pkg::ST_FAULT
				|| state == pssbc_pkg::ST_OFF) begin
				PWM_OUT <= '0;
				VALID_OUT <= '0;
			end else begin
				PWM_OUT <= next_pwm;
				VALID_OUT <= active;
			end
		end
	end

	AST_GROUP_RESET: assert property (@(posedge MCLK)
		$past(SRST) && !SRST |-> channel_shutdown_group == 8'h30)
		else $error("Group register did not reset to 0x30.");

	AST_GROUP_WRITE: assert property (@(posedge MCLK) disable iff (SRST)
		wr_pend && wr_idx == 8'h19 |=> channel_shutdown_group[7:6] == 2'b00
		&& channel_shutdown_group[5:0] == $past(HWDATA[5:0]))
		else $error("Group membership bits not stored per channel.");

	AST_START_SET: assert property (@(posedge MCLK) disable iff (SRST)
		state == pssbc_pkg::ST_OFF && start_req && fault_n_s && !ctrl[5]
		|=> active == ~$past(channel_shutdown_group[5:0]))
		else $error("Member channels were started.");

	AST_SOFT_HALF: assert property (@(posedge MCLK) disable iff (SRST)
		(state == pssbc_pkg::ST_SOFT_START || state == pssbc_pkg::ST_SOFT_STOP)
		&& fault_n_s |=> PWM_OUT == ($past(half_wave) ? $past(active) : 6'h00))
		else $error("Soft period output is not the half duty wave.");

	AST_LOAD_MODE: assert property (@(posedge MCLK) disable iff (SRST)
		$changed(soft_start_stop_period[7]) |=> ##1
		SINGLE_ENDED_LOAD == $past(soft_start_stop_period[7], 2))
		else $error("Load mode output does not follow period bit 7.");

	AST_SKIP_SOFT: assert property (@(posedge MCLK) disable iff (SRST)
		state == pssbc_pkg::ST_OFF && start_req && fault_n_s
		&& soft_start_stop_period[4:3] == 2'b00 |=> state == pssbc_pkg::ST_RUN)
		else $error("Soft period not skipped for code zero.");

	AST_SOFT_TABLE: assert property (@(posedge MCLK) disable iff (SRST)
		state == pssbc_pkg::ST_OFF && start_req && fault_n_s
		&& soft_start_stop_period[4:0] == 5'h08 |=> wait_cnt == 18'd165)
		else $error("Soft period for the shortest code is wrong.");

	AST_TRIM_TIME: assert property (@(posedge MCLK) disable iff (SRST)
		$fell(oscillator_trim_control[1]) |-> ##[1:TRIM_WAIT_MAX] trim_done)
		else $error("Trim did not complete after enabling.");

	AST_TRIM_DONE_HOLD: assert property (@(posedge MCLK) disable iff (SRST)
		$fell(trim_done) |-> $past(oscillator_trim_control[1]))
		else $error("Trim done fell while trim stayed enabled.");

	AST_FAULT_LOW: assert property (@(posedge MCLK) disable iff (SRST)
		!fault_n_s |=> PWM_OUT == 6'h00 && VALID_OUT == 6'h00)
		else $error("Outputs not forced low on a power stage fault.");

	AST_FAULT_WAIT: assert property (@(posedge MCLK) disable iff (SRST)
		state == pssbc_pkg::ST_FAULT && wait_cnt != 18'd0
		|=> state == pssbc_pkg::ST_FAULT)
		else $error("Fault wait ended early.");

	AST_FAULT_TABLE: assert property (@(posedge MCLK) disable iff (SRST)
		!fault_n_s && state != pssbc_pkg::ST_FAULT && backend_fault_wait[3:0]
		>= 4'ha |=> wait_cnt == 18'd14960)
		else $error("Fault wait did not saturate for large codes.");
endmodule

// >>> sim/pssbc_stage_model.sv
// Behavioural power stage that raises a fault on command and flags misuse.
module pssbc_stage_model (
	input wire logic clk,
	input wire logic [5:0] pwm,
	input wire logic [5:0] valid,
	input wire logic fault_cmd,
	output logic fault_n,
	output logic misuse
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fault_n = 1'b1;
		misuse = 1'b0;
	end
	// A channel switching while its valid is low would be unsafe here.
	always @(posedge clk) begin
		fault_n <= !fault_cmd;
		if ((pwm & ~valid) != 6'h00) begin
			misuse <= 1'b1;
		end
	end
endmodule

// >>> sim/tb_pwm_start_stop_backend_ctrl.sv
// Self-checking bench for the start/stop, trim and fault control block.
`include "pssbc_params.svh"
module tb_pwm_start_stop_backend_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 2;
	localparam int HALF = 3;
	logic mclk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic fault_cmd = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [5:0] pwm_in = 6'h00, pwm_out, valid_out;
	logic hreadyout, hresp, irq, se_load, trim_apply, fault_n, misuse;
	int fail_count = 0;
	int comparisons = 0;

	pssbc_top #(.CHANNELS(6), .TICK_CYCLES(TICK), .HALF_CYCLES(HALF)) dut (
		.MCLK(mclk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .PWM_IN(pwm_in), .POWER_STAGE_FAULT_N(fault_n),
		.PWM_OUT(pwm_out), .VALID_OUT(valid_out),
		.SINGLE_ENDED_LOAD(se_load), .OSC_TRIM_APPLY(trim_apply), .IRQ(irq)
	);
	pssbc_stage_model stage (.clk(mclk), .pwm(pwm_out), .valid(valid_out),
		.fault_cmd(fault_cmd), .fault_n(fault_n), .misuse(misuse));

	initial begin
		forever #5 mclk = ~mclk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic timed_out();
		fail_count++;
		$display("unexpected at %0t: wait ran out", $time);
		report_and_stop();
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) timed_out();
	endtask
	// Single word transfer: address phase, then data phase.
	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
	endtask
	task automatic write_reg(input logic [7:0] idx, input logic [31:0] wd);
		xfer(1'b1, idx, wd);
	endtask
	task automatic read_check(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		check(hrdata, exp);
	endtask
	task automatic wait_on(input bit on_irq, input logic [5:0] exp,
		input int lim, output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((on_irq ? {5'h0, irq} : valid_out) !== exp && n < lim);
		if (n >= lim) timed_out();
	endtask

	task automatic reset_values();
		check({26'h0, valid_out}, 32'h0);
		check(32'(se_load), 32'h0);
		read_check(`PSSBC_IDX_GROUP, 32'h30);
		read_check(`PSSBC_IDX_PERIOD, 32'h0);
		read_check(`PSSBC_IDX_TRIM, 32'h82);
		read_check(`PSSBC_IDX_FAULT, 32'h2);
		write_reg(8'h3f, 32'hff);
		read_check(8'h3f, 32'h0);
		check(32'(hresp), 32'h0);
	endtask
	task automatic trim_enable();
		write_reg(`PSSBC_IDX_TRIM, 32'h0);
		write_reg(`PSSBC_IDX_TRIM, 32'h40);
		check(32'(trim_apply), 32'h1);
		read_check(`PSSBC_IDX_TRIM, 32'h80);
		repeat (40) @(posedge mclk);
		read_check(`PSSBC_IDX_TRIM, 32'hc0);
		write_reg(`PSSBC_IDX_TRIM, 32'h2);
		@(posedge mclk);
		read_check(`PSSBC_IDX_TRIM, 32'h82);
		check(32'(trim_apply), 32'h0);
		write_reg(`PSSBC_IDX_TRIM, 32'h0);
	endtask
	task automatic soft_start();
		int hi, lo, n;
		hi = 0;
		lo = 0;
		write_reg(`PSSBC_IDX_MASK, 32'h2);
		write_reg(`PSSBC_IDX_PERIOD, 32'h8);
		write_reg(`PSSBC_IDX_CTRL, 32'h0);
		repeat (2) @(posedge mclk);
		repeat (4 * HALF) begin
			@(posedge mclk);
			hi += int'(pwm_out === 6'h0f && valid_out === 6'h0f);
			lo += int'(pwm_out === 6'h00 && valid_out === 6'h0f);
		end
		check(32'(hi), 32'(2 * HALF));
		check(32'(lo), 32'(2 * HALF));
		wait_on(1'b1, 6'h01, 1000, n);
		n += 4 * HALF + 2;
		check(32'(n >= 165 * TICK && n <= 165 * TICK + 15), 32'h1);
		pwm_in <= 6'h15;
		repeat (3) @(posedge mclk);
		check({26'h0, pwm_out}, 32'h05);
		read_check(`PSSBC_IDX_STATUS, 32'ha);
		write_reg(`PSSBC_IDX_STATUS, 32'h2);
		repeat (2) @(posedge mclk);
		check(32'(irq), 32'h0);
		write_reg(`PSSBC_IDX_CTRL, 32'h1);
		repeat (3) @(posedge mclk);
		check({26'h0, valid_out}, 32'h0f);
		wait_on(1'b0, 6'h00, 400, n);
		n += 3;
		check(32'(n >= 165 * TICK && n <= 165 * TICK + 15), 32'h1);
	endtask
	task automatic group_and_stop();
		int n;
		write_reg(`PSSBC_IDX_PERIOD, 32'h80);
		repeat (2) @(posedge mclk);
		check(32'(se_load), 32'h1);
		write_reg(`PSSBC_IDX_CTRL, 32'h1);
		wait_on(1'b0, 6'h00, 10, n);
		write_reg(`PSSBC_IDX_GROUP, 32'hff);
		read_check(`PSSBC_IDX_GROUP, 32'h3f);
		write_reg(`PSSBC_IDX_GROUP, 32'h2a);
		write_reg(`PSSBC_IDX_CTRL, 32'h0);
		wait_on(1'b0, 6'h15, 10, n);
		write_reg(`PSSBC_IDX_CTRL, 32'h1);
		wait_on(1'b0, 6'h00, 10, n);
		write_reg(`PSSBC_IDX_CTRL, 32'h20);
		wait_on(1'b0, 6'h3f, 10, n);
	endtask
	task automatic fault_recovery();
		int n;
		pwm_in <= 6'h3f;
		write_reg(`PSSBC_IDX_FAULT, 32'hf);
		read_check(`PSSBC_IDX_FAULT, 32'hf);
		write_reg(`PSSBC_IDX_PERIOD, 32'h0);
		fault_cmd <= 1'b1;
		repeat (5) @(posedge mclk);
		check({20'h0, pwm_out, valid_out}, 32'h0);
		fault_cmd <= 1'b0;
		wait_on(1'b0, 6'h3f, 40000, n);
		n += 5;
		check(32'(n >= 14960 * TICK && n <= 14960 * TICK + 30), 32'h1);
		check(32'(misuse), 32'h0);
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		reset_values();
		trim_enable();
		soft_start();
		group_and_stop();
		fault_recovery();
		report_and_stop();
	end
endmodule
